// file: rtl/nest_irq_pkg.sv
// package for the nested interrupt mask controller: register map, fields, reset values, latencies
// assumes a 32-bit apb slave on one core clock
package nest_irq_pkg;
	localparam int irq_count = 32;
	localparam logic [7:0] addr_mode = 8'h00;
	localparam logic [7:0] addr_latch = 8'h04;
	localparam logic [7:0] addr_mask = 8'h08;
	localparam logic [7:0] addr_nest_ptr = 8'h0c;
	localparam logic [7:0] addr_seq_cmd = 8'h10;
	localparam logic [7:0] addr_status = 8'h14;
	localparam logic [7:0] addr_pc_stack_ptr = 8'h18;
	localparam logic [7:0] addr_fetch = 8'h1c;
	localparam logic [7:0] addr_pc_top = 8'h20;
	localparam int nesting_enable_bit = 11;
	localparam int global_irq_enable_bit = 12;
	localparam int saturate_bit = 13;
	localparam int cmd_rti_bit = 0;
	localparam int cmd_jci_bit = 1;
	localparam int cmd_idle_bit = 2;
	localparam int cmd_rts_bit = 3;
	localparam logic [31:0] mode_reset = 32'h0000_0000;
	localparam logic [31:0] mask_reset = 32'h0000_0000;
	localparam logic [31:0] zero_word = 32'h0000_0000;
	localparam logic [4:0] pc_ptr_reset = 5'h00;
	localparam logic [1:0] wake_cycles = 2'h2;
	localparam logic [1:0] saturate_delay = 2'h2;
	localparam int pc_depth = 32;

	typedef struct packed {
		logic [31:0] latch;
		logic [31:0] nest_ptr;
	} irq_state_type;

	typedef enum logic [3:0] {
		seq_run = 4'b0001,
		seq_idle_fetch = 4'b0010,
		seq_halted = 4'b0100,
		seq_wake = 4'b1000
	} seq_state_type;
endpackage

// file: rtl/pc_stack_mem.sv
// small memory for the program counter stack; read data come out of a register
// assumes single core clock, one write per cycle
`timescale 1ns/10ps
`default_nettype none
module pc_stack_mem (
	// clock and enable
	input wire logic core_clk,
	input wire logic clk_en,
	// write side
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [23:0] wr_data,
	// read side
	input wire logic [4:0] rd_addr,
	output logic [23:0] rd_data
);
	logic [23:0] mem [0:nest_irq_pkg::pc_depth-1];
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

// file: rtl/prio_pick.sv
// picks the highest priority set bit (bit 0 highest) as one-hot
// assumes pure combinational use
`timescale 1ns/10ps
`default_nettype none
module prio_pick (
	// request vector
	input wire logic [31:0] req,
	// one-hot winner
	output logic [31:0] win
);
	always_comb begin
		win = nest_irq_pkg::zero_word;
		for (int i = 31; i >= 0; i--) begin
			if (req[i]) begin
				win = nest_irq_pkg::zero_word;
				win[i] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/nested_interrupt_mask_control.sv
// nested interrupt mask controller with halt/wake and sequencer register latencies
// assumes an apb master on core_clk and irq sources synchronous or from pins (synchronised here)
// Contract
// - with nesting, a preempting request right after another starts one cycle late
// - temporary mask per level from nest pointer; mask register left untouched
// - taking a request sets its pointer bit; nesting masks equal and lower
// - return-from-irq clears highest set pointer bit and recomputes mask
// - highest set pointer bit equals the request now in service
// - latch bit set on event, cleared every cycle during its service
// - jump-clear-irq clears latch and pointer bit, pops status, stops auto-clear
// - halt holds core until a request is latched and taken, then wakes
// - halt fetches one more instruction at current fetch address then stops
// - while halted, dma, internal clock and timers keep running
// - wake-up spends two cycles fetching and decoding first routine instruction
// - sequencer registers readable and writable except fetch and decode addresses; here status and pc top are read-only, the command register write-only
// - writing pc stack pointer pushes or pops the pc stack
// - mode, latch, mask read back at once; mode and mask take effect one cycle later, latch at once
// - nest pointer has one extra read cycle and no extra effect cycle
// - saturation enable acts two cycles after the mode write
// - bit 0 highest priority, bit 31 lowest, decides simultaneous requests
// - mode bit 11 enables nesting
`timescale 1ns/10ps
`default_nettype none
module nested_interrupt_mask_control (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt sources (pins)
	input wire logic [31:0] irq_in,
	// sequencer side
	input wire logic [23:0] next_fetch_addr,
	output logic [31:0] irq_take,
	output logic core_run,
	output logic fetch_en,
	output logic alu_saturate,
	output logic [23:0] pc_stack_top
);
	logic [31:0] irq_meta_reg, irq_sync_reg, irq_prev_reg;
	logic [31:0] mode_reg, mode_next, mask_reg, mask_next;
	logic [31:0] mode_eff_reg, mask_eff_reg, ptr_eff_reg, ptr_view_reg;
	logic [31:0] latch_reg, latch_next, ptr_reg, ptr_next;
	logic [31:0] serving_reg, serving_next, reuse_reg, reuse_next;
	logic [31:0] take_reg, take_next, hold_reg, hold_next;
	logic [31:0] prdata_reg, prdata_next, temp_mask, pend, winner, ptr_top;
	logic [4:0] pc_ptr_reg, pc_ptr_next;
	logic [23:0] fetch_reg, fetch_next;
	logic [1:0] wake_cnt_reg, wake_cnt_next, sat_cnt_reg, sat_cnt_next;
	logic sat_reg, sat_next, just_took_reg, just_took_next, pready_reg;
	logic halted_by_idle_reg, halted_by_idle_next;
	logic pc_wr;
	logic [23:0] pc_rd;
	logic core_run_reg, core_run_next, fetch_en_reg, fetch_en_next;
	nest_irq_pkg::seq_state_type st_reg, st_next;

	wire logic wr_acc = psel && penable && pwrite;
	wire logic rd_acc = psel && !penable && !pwrite;
	wire logic cmd_wr = wr_acc && (paddr == nest_irq_pkg::addr_seq_cmd);
	// rising edges of the synchronised requests; a latch set beats a software clear
	wire logic [31:0] irq_edge = irq_sync_reg & ~irq_prev_reg;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a <= nest_irq_pkg::addr_pc_top) && (a[1:0] == 2'h0);
	endfunction

	prio_pick pick_pend (.req(pend), .win(winner));
	prio_pick pick_top (.req(ptr_eff_reg), .win(ptr_top));

	// read address looks one slot below the pointer it will hold
	pc_stack_mem pc_mem (
		.core_clk(core_clk),
		.clk_en(clk_en),
		.wr_en(pc_wr),
		.wr_addr(pc_ptr_reg),
		.wr_data(fetch_reg),
		.rd_addr(pc_ptr_next - 5'h01),
		.rd_data(pc_rd)
	);

	// temporary mask: everything at or below the top pointer bit is closed
	always_comb begin
		temp_mask = mask_eff_reg;
		if (ptr_eff_reg != nest_irq_pkg::zero_word) begin
			if (mode_eff_reg[nest_irq_pkg::nesting_enable_bit]) begin
				for (int i = 0; i < nest_irq_pkg::irq_count; i++) begin
					// closed when the top pointer bit sits at or above this position
					if ((ptr_top & ((32'h0000_0002 << i) - 32'h0000_0001)) != nest_irq_pkg::zero_word) begin
						temp_mask[i] = 1'b0;
					end
				end
			end else begin
				temp_mask = nest_irq_pkg::zero_word;
			end
		end
		pend = latch_reg & temp_mask & {32{mode_eff_reg[nest_irq_pkg::global_irq_enable_bit]}};
	end

	always_comb begin
		mode_next = mode_reg;
		mask_next = mask_reg;
		latch_next = latch_reg | irq_edge;
		ptr_next = ptr_reg;
		serving_next = serving_reg;
		reuse_next = reuse_reg;
		take_next = nest_irq_pkg::zero_word;
		hold_next = hold_reg;
		just_took_next = 1'b0;
		pc_ptr_next = pc_ptr_reg;
		pc_wr = 1'b0;
		st_next = st_reg;
		fetch_next = next_fetch_addr;
		wake_cnt_next = wake_cnt_reg;
		halted_by_idle_next = halted_by_idle_reg;
		sat_next = sat_reg;
		sat_cnt_next = (sat_cnt_reg != 2'h0) ? sat_cnt_reg - 2'h1 : 2'h0;
		// saturation follows the mode bit two edges after the write
		if (sat_cnt_reg == 2'h1) begin
			sat_next = mode_reg[nest_irq_pkg::saturate_bit];
		end
		if (wr_acc && known_addr(paddr)) begin
			case (paddr)
				nest_irq_pkg::addr_mode: begin
					mode_next = pwdata;
					sat_cnt_next = nest_irq_pkg::saturate_delay;
				end
				nest_irq_pkg::addr_latch: latch_next = pwdata | irq_edge;
				nest_irq_pkg::addr_mask: mask_next = pwdata;
				nest_irq_pkg::addr_nest_ptr: ptr_next = pwdata;
				// a pointer written above its value pushes the current fetch address
				nest_irq_pkg::addr_pc_stack_ptr: begin
					pc_ptr_next = pwdata[4:0];
					pc_wr = (pwdata[4:0] > pc_ptr_reg);
				end
				default: ;
			endcase
		end
		// service in progress keeps its latch bits clear until a jump-clear-irq marks it for reuse
		latch_next = latch_next & ~(serving_reg & ~reuse_reg);
		if (cmd_wr && pwdata[nest_irq_pkg::cmd_rti_bit] && ptr_reg != nest_irq_pkg::zero_word) begin
			ptr_next = ptr_next & ~ptr_top;
			serving_next = serving_reg & ~ptr_top;
			reuse_next = reuse_reg & ~ptr_top;
			if (halted_by_idle_reg) begin
				halted_by_idle_next = 1'b0;
			end
		end
		// the status stack pop is carried by stepping the pc stack pointer back
		if (cmd_wr && pwdata[nest_irq_pkg::cmd_jci_bit]) begin
			ptr_next = ptr_next & ~ptr_top;
			latch_next = latch_next & ~ptr_top;
			reuse_next = reuse_reg | ptr_top;
			pc_ptr_next = pc_ptr_reg - 5'h01;
		end
		if (cmd_wr && pwdata[nest_irq_pkg::cmd_rts_bit]) begin
			serving_next = serving_reg & ~reuse_reg;
			reuse_next = nest_irq_pkg::zero_word;
		end
		// a pending winner is delayed one cycle after a previous take
		if (winner != nest_irq_pkg::zero_word && !just_took_reg && hold_reg == nest_irq_pkg::zero_word) begin
			hold_next = winner;
		end else if (hold_reg != nest_irq_pkg::zero_word) begin
			take_next = hold_reg;
			hold_next = nest_irq_pkg::zero_word;
			ptr_next = ptr_next | hold_reg;
			serving_next = serving_next | hold_reg;
			latch_next = latch_next & ~hold_reg;
			just_took_next = 1'b1;
		end
		case (st_reg)
			nest_irq_pkg::seq_run: begin
				if (cmd_wr && pwdata[nest_irq_pkg::cmd_idle_bit]) begin
					st_next = nest_irq_pkg::seq_idle_fetch;
					halted_by_idle_next = 1'b1;
				end
			end
			// one more fetch slips through before the core stops
			nest_irq_pkg::seq_idle_fetch: begin
				fetch_next = fetch_reg;
				st_next = nest_irq_pkg::seq_halted;
			end
			nest_irq_pkg::seq_halted: begin
				fetch_next = fetch_reg;
				if (take_next != nest_irq_pkg::zero_word) begin
					st_next = nest_irq_pkg::seq_wake;
					wake_cnt_next = nest_irq_pkg::wake_cycles;
				end
			end
			nest_irq_pkg::seq_wake: begin
				wake_cnt_next = wake_cnt_reg - 2'h1;
				if (wake_cnt_reg == 2'h1) begin
					st_next = nest_irq_pkg::seq_run;
				end
			end
			default: st_next = nest_irq_pkg::seq_run;
		endcase
		core_run_next = (st_next == nest_irq_pkg::seq_run);
		fetch_en_next = (st_next != nest_irq_pkg::seq_halted);
		// read data are caught at the setup edge, so the access phase needs no wait state
		prdata_next = nest_irq_pkg::zero_word;
		if (rd_acc && known_addr(paddr)) begin
			case (paddr)
				nest_irq_pkg::addr_mode: prdata_next = mode_reg;
				nest_irq_pkg::addr_latch: prdata_next = latch_reg;
				nest_irq_pkg::addr_mask: prdata_next = mask_reg;
				nest_irq_pkg::addr_nest_ptr: prdata_next = ptr_view_reg;
				nest_irq_pkg::addr_status: prdata_next = {27'h0, halted_by_idle_reg, st_reg};
				nest_irq_pkg::addr_pc_stack_ptr: prdata_next = {27'h0, pc_ptr_reg};
				nest_irq_pkg::addr_pc_top: prdata_next = {8'h00, pc_rd};
				default: prdata_next = nest_irq_pkg::zero_word;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_meta_reg <= nest_irq_pkg::zero_word;
			irq_sync_reg <= nest_irq_pkg::zero_word;
			irq_prev_reg <= nest_irq_pkg::zero_word;
			mode_reg <= nest_irq_pkg::mode_reset;
			mask_reg <= nest_irq_pkg::mask_reset;
			mode_eff_reg <= nest_irq_pkg::mode_reset;
			mask_eff_reg <= nest_irq_pkg::mask_reset;
			latch_reg <= nest_irq_pkg::zero_word;
			ptr_reg <= nest_irq_pkg::zero_word;
			ptr_eff_reg <= nest_irq_pkg::zero_word;
			ptr_view_reg <= nest_irq_pkg::zero_word;
			serving_reg <= nest_irq_pkg::zero_word;
			reuse_reg <= nest_irq_pkg::zero_word;
			take_reg <= nest_irq_pkg::zero_word;
			hold_reg <= nest_irq_pkg::zero_word;
			just_took_reg <= 1'b0;
			pc_ptr_reg <= nest_irq_pkg::pc_ptr_reset;
			fetch_reg <= 24'h000000;
			st_reg <= nest_irq_pkg::seq_run;
			core_run_reg <= 1'b1;
			fetch_en_reg <= 1'b1;
			wake_cnt_reg <= 2'h0;
			halted_by_idle_reg <= 1'b0;
			sat_reg <= 1'b0;
			sat_cnt_reg <= 2'h0;
			prdata_reg <= nest_irq_pkg::zero_word;
			pready_reg <= 1'b0;
		end else if (clk_en) begin
			irq_meta_reg <= irq_in;
			irq_sync_reg <= irq_meta_reg;
			irq_prev_reg <= irq_sync_reg;
			mode_reg <= mode_next;
			mask_reg <= mask_next;
			// effect latency: the masks act one edge after the register takes the write
			mode_eff_reg <= mode_reg;
			mask_eff_reg <= mask_reg;
			latch_reg <= latch_next;
			ptr_reg <= ptr_next;
			// the nest pointer reads back one edge later than the plain registers
			ptr_view_reg <= ptr_reg;
			ptr_eff_reg <= ptr_next;
			serving_reg <= serving_next;
			reuse_reg <= reuse_next;
			take_reg <= take_next;
			hold_reg <= hold_next;
			just_took_reg <= just_took_next;
			pc_ptr_reg <= pc_ptr_next;
			fetch_reg <= fetch_next;
			st_reg <= st_next;
			core_run_reg <= core_run_next;
			fetch_en_reg <= fetch_en_next;
			wake_cnt_reg <= wake_cnt_next;
			halted_by_idle_reg <= halted_by_idle_next;
			sat_reg <= sat_next;
			sat_cnt_reg <= sat_cnt_next;
			if (rd_acc) begin
				prdata_reg <= prdata_next;
			end
			pready_reg <= psel && !penable;
		end
	end

	always_comb begin
		// every output except the constant pslverr is a register or the memory's read register
		prdata = prdata_reg;
		pready = pready_reg;
		pslverr = 1'b0;
		irq_take = take_reg;
		core_run = core_run_reg;
		fetch_en = fetch_en_reg;
		alu_saturate = sat_reg;
		pc_stack_top = pc_rd;
	end
endmodule
`default_nettype wire

// file: dv/nest_irq_assertions.sv
// port checker for the nested interrupt mask controller
// assumes binding to nested_interrupt_mask_control, one core clock
`timescale 1ns/10ps
`default_nettype none
module nest_irq_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// sequencer side
	input wire logic [31:0] irq_take,
	input wire logic core_run,
	input wire logic fetch_en,
	input wire logic alu_saturate
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence sat_wr_s;
		psel && penable && pwrite && paddr == nest_irq_pkg::addr_mode && pwdata[nest_irq_pkg::saturate_bit];
	endsequence
	AST_READY_AFTER_SETUP: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_NO_ERROR: assert property (!pslverr)
		else $error("slave error raised");
	AST_TAKE_ONEHOT: assert property ($onehot0(irq_take))
		else $error("two requests taken at once");
	AST_TAKE_ONCE: assert property (|irq_take |=> (irq_take & $past(irq_take)) == 32'h0)
		else $error("request taken twice in a row");
	AST_HALT_STOPS: assert property (!fetch_en |-> !core_run)
		else $error("core runs while fetch is off");
	AST_WAKE_TWO: assert property ($rose(core_run) |-> !$past(core_run, 2))
		else $error("wake shorter than two cycles");
	AST_SAT_DELAY: assert property (sat_wr_s |-> ##[2:3] alu_saturate)
		else $error("saturation not applied in time");
	AST_PRDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed without a read");
endmodule
bind nested_interrupt_mask_control nest_irq_assertions u_nest_irq_assertions (.core_clk, .reset_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_take, .core_run, .fetch_en, .alu_saturate);
`default_nettype wire

// file: dv/irq_source_model.sv
// model of the interrupt sources and the instruction fetch side
// assumes core_clk domain; the bench raises requests through raise()
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// from the controller
	input wire logic [31:0] irq_take,
	input wire logic fetch_en,
	// to the controller
	output logic [31:0] irq_in,
	output logic [23:0] next_fetch_addr
);
	// raise() only flips a toggle, so irq_in keeps a single writer
	logic [31:0] raise_tog = 32'h0;
	logic [31:0] raise_seen;
	// a source holds its level until taken, so a later raise is a fresh edge
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_in <= 32'h0;
			next_fetch_addr <= 24'h0;
			raise_seen <= 32'h0;
		end else begin
			raise_seen <= raise_tog;
			irq_in <= (irq_in | (raise_tog ^ raise_seen)) & ~irq_take;
			if (fetch_en)
				next_fetch_addr <= next_fetch_addr + 24'h4;
		end
	end
	task automatic raise(input int b);
		raise_tog[b] <= ~raise_tog[b];
	endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the nested interrupt mask controller
// assumes the package, the design, the source model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel, penable, pwrite, clk_en;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [23:0] pc_stack_top, t1;
	logic [31:0] prdata, irq_in, irq_take, q;
	logic [23:0] next_fetch_addr;
	logic pready, pslverr, core_run, fetch_en, alu_saturate;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 core_clk = ~core_clk;
	nested_interrupt_mask_control u_nested_interrupt_mask_control (.core_clk, .reset_n, .clk_en, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_in, .next_fetch_addr, .irq_take,
		.core_run, .fetch_en, .alu_saturate, .pc_stack_top);
	irq_source_model u_irq_source_model (.core_clk, .reset_n, .irq_take, .fetch_en, .irq_in, .next_fetch_addr);
	task automatic finish_test;
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic cmd(input int b);
		apb(1'b1, nest_irq_pkg::addr_seq_cmd, 32'h1 << b);
	endtask
	// scans a fixed window so that an absent take is seen as well
	task automatic wt(input int b, input logic e);
		logic s;
		s = 1'b0;
		repeat (40) begin
			@(posedge core_clk);
			if (irq_take[b] === 1'b1)
				s = 1'b1;
		end
		chk({31'h0, s}, {31'h0, e});
	endtask
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		clk_en <= 1'b1;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		chk({30'h0, core_run, fetch_en}, 32'h3);
		rd(nest_irq_pkg::addr_mode, 32'h0);
		apb(1'b1, nest_irq_pkg::addr_mask, 32'hac);
		rd(nest_irq_pkg::addr_mask, 32'hac);
		rd(nest_irq_pkg::addr_fetch, 32'h0);
		apb(1'b1, nest_irq_pkg::addr_mode, 32'h1000);
		u_irq_source_model.raise(5);
		wt(5, 1'b1);
		rd(nest_irq_pkg::addr_nest_ptr, 32'h20);
		apb(1'b0, nest_irq_pkg::addr_latch, 32'h0);
		chk(q & 32'h20, 32'h0);
		u_irq_source_model.raise(2);
		wt(2, 1'b0);
		cmd(nest_irq_pkg::cmd_rti_bit);
		wt(2, 1'b1);
		cmd(nest_irq_pkg::cmd_rti_bit);
		rd(nest_irq_pkg::addr_nest_ptr, 32'h0);
		apb(1'b1, nest_irq_pkg::addr_mode, 32'h1800);
		u_irq_source_model.raise(5);
		wt(5, 1'b1);
		u_irq_source_model.raise(2);
		wt(2, 1'b1);
		rd(nest_irq_pkg::addr_nest_ptr, 32'h24);
		rd(nest_irq_pkg::addr_mask, 32'hac);
		u_irq_source_model.raise(7);
		wt(7, 1'b0);
		cmd(nest_irq_pkg::cmd_rti_bit);
		rd(nest_irq_pkg::addr_nest_ptr, 32'h20);
		cmd(nest_irq_pkg::cmd_rti_bit);
		wt(7, 1'b1);
		cmd(nest_irq_pkg::cmd_jci_bit);
		rd(nest_irq_pkg::addr_nest_ptr, 32'h0);
		u_irq_source_model.raise(7);
		wt(7, 1'b1);
		cmd(nest_irq_pkg::cmd_rti_bit);
		cmd(nest_irq_pkg::cmd_rts_bit);
		cmd(nest_irq_pkg::cmd_idle_bit);
		repeat (20) if (fetch_en !== 1'b0) @(posedge core_clk);
		chk({31'h0, fetch_en}, 32'h0);
		u_irq_source_model.raise(3);
		wt(3, 1'b1);
		cmd(nest_irq_pkg::cmd_rti_bit);
		repeat (10) @(posedge core_clk);
		chk({31'h0, core_run}, 32'h1);
		apb(1'b1, nest_irq_pkg::addr_mode, 32'h3000);
		repeat (4) @(posedge core_clk);
		chk({31'h0, alu_saturate}, 32'h1);
		apb(1'b1, nest_irq_pkg::addr_pc_stack_ptr, 32'h1);
		rd(nest_irq_pkg::addr_pc_stack_ptr, 32'h1);
		apb(1'b1, nest_irq_pkg::addr_pc_stack_ptr, 32'h2);
		@(posedge core_clk);
		t1 = pc_stack_top;
		chk({30'h0, t1[1:0]}, 32'h0);
		apb(1'b1, nest_irq_pkg::addr_pc_stack_ptr, 32'h3);
		@(posedge core_clk);
		chk({31'h0, pc_stack_top !== t1}, 32'h1);
		apb(1'b1, nest_irq_pkg::addr_pc_stack_ptr, 32'h2);
		@(posedge core_clk);
		chk({8'h0, pc_stack_top}, {8'h0, t1});
		rd(nest_irq_pkg::addr_pc_top, {8'h0, t1});
		clk_en <= 1'b0;
		u_irq_source_model.raise(3);
		wt(3, 1'b0);
		clk_en <= 1'b1;
		wt(3, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
